/* File: hdl/psr_pkg.sv */
`default_nettype none
package psr_pkg;
  localparam int CLK_HZ     = 40_000_000;
  localparam int BAUD_9600  = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  // Cycles per bit at the slowest rate, rounded to nearest (4167)
  localparam logic [15:0] DIV_9600 = 16'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [15:0] MUL_19200 = 16'(BAUD_19200 / BAUD_9600);
  localparam logic [15:0] MUL_38400 = 16'(BAUD_38400 / BAUD_9600);
  localparam logic [15:0] MUL_57600 = 16'(BAUD_57600 / BAUD_9600);

  localparam int DATA_BITS = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] NEAR_FULL_LEVEL = 5'h0C;

  typedef enum logic [1:0] {
    RATE_9600  = 2'b00,
    RATE_19200 = 2'b01,
    RATE_38400 = 2'b10,
    RATE_57600 = 2'b11
  } psr_rate_e;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD  = 2'b10
  } psr_parity_e;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_START = 3'b001,
    SER_DATA  = 3'b010,
    SER_PAR   = 3'b011,
    SER_STOP  = 3'b100
  } psr_ser_e;

  localparam logic [7:0] CH_STX  = 8'h02;
  localparam logic [7:0] CH_ETX  = 8'h03;
  localparam logic [7:0] CH_ACK  = 8'h06;
  localparam logic [7:0] CH_NAK  = 8'h15;
  localparam logic [7:0] CH_XON  = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STAT   = 12'h004;
  localparam logic [11:0] REG_TXDATA = 12'h008;
  localparam logic [11:0] REG_RXDATA = 12'h00C;
  localparam logic [6:0]  CTRL_RESET = 7'h00;

  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_PAR_LSB  = 2;
  localparam int CTRL_ONLINE   = 4;
  localparam int CTRL_XONOFF   = 5;
  localparam int CTRL_FAULT    = 6;

  localparam int STAT_EMPTY   = 0;
  localparam int STAT_FULL    = 1;
  localparam int STAT_NEAR    = 2;
  localparam int STAT_TXBUSY  = 3;
  localparam int STAT_RXBUSY  = 4;
  localparam int STAT_STK_LSB = 5;
  localparam int STAT_COUNT   = 16;
  localparam logic [6:0] STICKY_RESET = 7'h00;

  function automatic logic [15:0] psr_div(input logic [1:0] rate, input logic [15:0] base);
    case (rate)
      RATE_19200: psr_div = base / MUL_19200;
      RATE_38400: psr_div = base / MUL_38400;
      RATE_57600: psr_div = base / MUL_57600;
      default:    psr_div = base;
    endcase
  endfunction : psr_div

  function automatic logic psr_par_bit(input logic [1:0] mode, input logic [7:0] d);
    psr_par_bit = (mode == PAR_ODD) ? ~(^d) : (^d);
  endfunction : psr_par_bit
endpackage : psr_pkg
`default_nettype wire

/* File: hdl/psr_link_if.sv */
`default_nettype none
interface psr_link_if;
  logic rd;
  logic td;
  logic cts;
  logic dtr;
  logic rts;
  modport printer (input rd, input cts, output td, output dtr, output rts);
  modport host (output rd, output cts, input td, input dtr, input rts);
endinterface : psr_link_if
`default_nettype wire

/* File: hdl/psr_printer_end.sv */
`default_nettype none
module psr_fifo
  import psr_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign count     = wr_ptr_reg - rd_ptr_reg;
  assign in_ready  = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW + 1)'(pop);
    end
  end
endmodule : psr_fifo

module psr_uart_tx
  import psr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [7:0]  data,
  input  wire logic [1:0]  parity,
  input  wire logic [15:0] div,
  output logic             line_reg,
  output logic             busy
);
  psr_ser_e    state_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  sh_reg;
  wire         tick = (cnt_reg == 16'h0000);

  assign busy = (state_reg != SER_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SER_IDLE;
      cnt_reg   <= 16'h0000;
      idx_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      line_reg  <= 1'b1;
    end
    else
    begin
      cnt_reg <= tick ? div - 16'h0001 : cnt_reg - 16'h0001;
      case (state_reg)
        SER_IDLE:
        begin
          cnt_reg <= div - 16'h0001;
          if (start)
          begin
            sh_reg    <= data;
            line_reg  <= 1'b0;
            idx_reg   <= 3'h0;
            state_reg <= SER_START;
          end
        end
        SER_START:
          if (tick)
          begin
            line_reg  <= sh_reg[0];
            state_reg <= SER_DATA;
          end
        SER_DATA:
          if (tick)
          begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == 3'(DATA_BITS - 1))
            begin
              if (parity != PAR_NONE)
              begin
                line_reg  <= psr_par_bit(parity, sh_reg);
                state_reg <= SER_PAR;
              end
              else
              begin
                line_reg  <= 1'b1;
                state_reg <= SER_STOP;
              end
            end
            else
              line_reg <= sh_reg[idx_reg + 3'h1];
          end
        SER_PAR:
          if (tick)
          begin
            line_reg  <= 1'b1;
            state_reg <= SER_STOP;
          end
        SER_STOP:
          if (tick)
            state_reg <= SER_IDLE;
        default: state_reg <= SER_IDLE;
      endcase
    end
  end
endmodule : psr_uart_tx

module psr_uart_rx
  import psr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        line,
  input  wire logic        enable,
  input  wire logic [1:0]  parity,
  input  wire logic [15:0] div,
  output logic [7:0]       data_reg,
  output logic             valid_reg,
  output logic             perr_reg,
  output logic             ferr_reg,
  output logic             busy
);
  psr_ser_e    state_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  sh_reg;
  logic        pbad_reg;
  logic        s1_reg;
  logic        s2_reg;
  logic        s3_reg;
  logic        lvl_reg;
  wire         tick = (cnt_reg == 16'h0000);

  assign busy = (state_reg != SER_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      lvl_reg   <= 1'b1;
      state_reg <= SER_IDLE;
      cnt_reg   <= 16'h0000;
      idx_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      pbad_reg  <= 1'b0;
      data_reg  <= 8'h00;
      valid_reg <= 1'b0;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
    end
    else
    begin
      s1_reg    <= line;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      if (s2_reg == s3_reg)
        lvl_reg <= s3_reg;
      valid_reg <= 1'b0;
      cnt_reg   <= tick ? div - 16'h0001 : cnt_reg - 16'h0001;
      case (state_reg)
        SER_IDLE:
        begin
          // Sample mid-bit: first wait is half a bit
          cnt_reg  <= {1'b0, div[15:1]};
          pbad_reg <= 1'b0;
          idx_reg  <= 3'h0;
          if (enable && !lvl_reg)
            state_reg <= SER_START;
        end
        SER_START:
          if (tick)
            state_reg <= lvl_reg ? SER_IDLE : SER_DATA;
        SER_DATA:
          if (tick)
          begin
            sh_reg  <= {lvl_reg, sh_reg[7:1]};
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == 3'(DATA_BITS - 1))
              state_reg <= (parity != PAR_NONE) ? SER_PAR : SER_STOP;
          end
        SER_PAR:
          if (tick)
          begin
            pbad_reg  <= (lvl_reg != psr_par_bit(parity, sh_reg));
            state_reg <= SER_STOP;
          end
        SER_STOP:
          if (tick)
          begin
            data_reg  <= sh_reg;
            valid_reg <= 1'b1;
            perr_reg  <= pbad_reg;
            ferr_reg  <= ~lvl_reg;
            state_reg <= SER_IDLE;
          end
        default: state_reg <= SER_IDLE;
      endcase
    end
  end
endmodule : psr_uart_rx

module psr_printer_end
  import psr_pkg::*;
#(
  parameter logic [15:0] BIT_DIV_9600 = DIV_9600
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  psr_link_if.printer      link
);
  logic [6:0]  ctrl_reg;
  logic [6:0]  sticky_reg;
  logic [6:0]  sticky_next;
  logic [7:0]  hold_reg;
  logic        hold_pend_reg;
  logic        xoff_sent_reg;
  logic        start_reg;
  logic [7:0]  start_data_reg;
  logic        dtr_reg;
  logic        rts_reg;
  logic        c1_reg;
  logic        c2_reg;
  logic        c3_reg;
  logic        cts_lvl_reg;

  wire  [1:0]  rate    = ctrl_reg[CTRL_RATE_LSB +: 2];
  wire  [1:0]  parity  = ctrl_reg[CTRL_PAR_LSB +: 2];
  wire         online  = ctrl_reg[CTRL_ONLINE] & ~ctrl_reg[CTRL_FAULT];
  wire  [15:0] div     = psr_div(rate, BIT_DIV_9600);
  wire         tx_busy;
  wire         rx_busy;
  wire  [7:0]  rx_data;
  wire         rx_valid;
  wire         rx_perr;
  wire         rx_ferr;
  wire         f_in_ready;
  wire         f_out_valid;
  wire  [7:0]  f_out_data;
  wire  [4:0]  f_count;
  wire         near_full = (f_count >= NEAR_FULL_LEVEL);
  wire         xonoff    = ctrl_reg[CTRL_XONOFF];

  wire         acc_done = psel & penable & pready;
  wire         wr_done  = acc_done & pwrite;
  wire         rd_done  = acc_done & ~pwrite;
  wire         hit_ctrl = (paddr == REG_CTRL);
  wire         hit_stat = (paddr == REG_STAT);
  wire         hit_tx   = (paddr == REG_TXDATA);
  wire         hit_rx   = (paddr == REG_RXDATA);
  wire         mapped   = hit_ctrl | hit_stat | hit_tx | hit_rx;
  wire         pop      = rd_done & hit_rx & f_out_valid;

  wire         rx_en    = cts_lvl_reg & ~tx_busy & ~start_reg & f_in_ready;
  wire         want_off = xonoff & near_full & ~xoff_sent_reg;
  wire         want_on  = xonoff & ~near_full & xoff_sent_reg;
  wire         can_tx   = ~tx_busy & ~rx_busy & ~start_reg;
  wire         go_flow  = can_tx & (want_off | want_on);
  wire         go_user  = can_tx & ~go_flow & hold_pend_reg;

  wire  [6:0]  sticky_set = {rx_valid & rx_ferr,
                             rx_valid & rx_perr,
                             rx_valid & rx_data[7],
                             rx_valid & (rx_data == CH_NAK),
                             rx_valid & (rx_data == CH_ACK),
                             rx_valid & (rx_data == CH_ETX),
                             rx_valid & (rx_data == CH_STX)};
  wire  [6:0]  sticky_clr = (wr_done & hit_stat) ? pwdata[STAT_STK_LSB +: 7] : 7'h00;
  wire  [31:0] stat_word  = {11'h000, f_count, 4'h0, sticky_reg, rx_busy,
                             tx_busy | hold_pend_reg | start_reg,
                             near_full, ~f_in_ready, ~f_out_valid};
  wire  [31:0] rd_word    = hit_ctrl ? {25'h0, ctrl_reg} :
                            hit_stat ? stat_word :
                            hit_rx   ? {24'h0, f_out_data} : 32'h0;

  // Set wins over a clear written in the same cycle
  assign sticky_next = (sticky_reg & ~sticky_clr) | sticky_set;

  psr_uart_tx u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (start_reg),
    .data     (start_data_reg),
    .parity   (parity),
    .div      (div),
    .line_reg (link.td),
    .busy     (tx_busy)
  );

  psr_uart_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .line      (link.rd),
    .enable    (rx_en),
    .parity    (parity),
    .div       (div),
    .data_reg  (rx_data),
    .valid_reg (rx_valid),
    .perr_reg  (rx_perr),
    .ferr_reg  (rx_ferr),
    .busy      (rx_busy)
  );

  psr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_valid),
    .in_ready  (f_in_ready),
    .in_data   (rx_data),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  assign link.dtr = dtr_reg;
  assign link.rts = rts_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      // One wait state: pready comes in the second access cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg       <= CTRL_RESET;
      sticky_reg     <= STICKY_RESET;
      hold_reg       <= 8'h00;
      hold_pend_reg  <= 1'b0;
      xoff_sent_reg  <= 1'b0;
      start_reg      <= 1'b0;
      start_data_reg <= 8'h00;
      dtr_reg        <= 1'b0;
      rts_reg        <= 1'b0;
      c1_reg         <= 1'b0;
      c2_reg         <= 1'b0;
      c3_reg         <= 1'b0;
      cts_lvl_reg    <= 1'b0;
    end
    else
    begin
      c1_reg     <= link.cts;
      c2_reg     <= c1_reg;
      c3_reg     <= c2_reg;
      if (c2_reg == c3_reg)
        cts_lvl_reg <= c3_reg;
      sticky_reg <= sticky_next;
      dtr_reg    <= online & ~near_full;
      rts_reg    <= ~ctrl_reg[CTRL_FAULT];
      start_reg  <= go_flow | go_user;
      if (wr_done && hit_ctrl)
        ctrl_reg <= pwdata[6:0];
      if (go_flow)
      begin
        start_data_reg <= want_off ? CH_XOFF : CH_XON;
        xoff_sent_reg  <= want_off;
      end
      else if (go_user)
      begin
        start_data_reg <= hold_reg;
        hold_pend_reg  <= 1'b0;
      end
      else if (wr_done && hit_tx && !hold_pend_reg)
      begin
        hold_reg      <= pwdata[7:0];
        hold_pend_reg <= 1'b1;
      end
      if (!xonoff)
        xoff_sent_reg <= 1'b0;
    end
  end
endmodule : psr_printer_end
`default_nettype wire

/* File: hdl/psr_host_end.sv */
`default_nettype none
module psr_host_end
  import psr_pkg::*;
#(
  parameter logic [15:0] BIT_DIV_9600 = DIV_9600
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  rate_sel,
  input  wire logic [1:0]  parity_sel,
  input  wire logic        xonoff_en,
  input  wire logic        send_valid,
  input  wire logic [7:0]  send_data,
  output logic             send_ready,
  output logic             recv_valid,
  output logic [7:0]       recv_data,
  output logic             recv_perr,
  output logic             recv_ferr,
  output logic             paused,
  psr_link_if.host         link
);
  logic        start_reg;
  logic [7:0]  data_reg;
  logic        cts_out_reg;
  logic        d1_reg;
  logic        d2_reg;
  logic        d3_reg;
  logic        dtr_lvl_reg;
  wire  [15:0] div = psr_div(rate_sel, BIT_DIV_9600);
  wire         tx_busy;
  wire         rx_busy;
  wire         accept  = send_valid & send_ready;
  wire         rx_en   = ~tx_busy & ~start_reg;
  wire         can_snd = dtr_lvl_reg & ~paused & ~tx_busy & ~rx_busy & ~start_reg & ~accept;

  psr_uart_tx u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (start_reg),
    .data     (data_reg),
    .parity   (parity_sel),
    .div      (div),
    .line_reg (link.rd),
    .busy     (tx_busy)
  );

  psr_uart_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .line      (link.td),
    .enable    (rx_en),
    .parity    (parity_sel),
    .div       (div),
    .data_reg  (recv_data),
    .valid_reg (recv_valid),
    .perr_reg  (recv_perr),
    .ferr_reg  (recv_ferr),
    .busy      (rx_busy)
  );

  assign link.cts = cts_out_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_reg   <= 1'b0;
      data_reg    <= 8'h00;
      send_ready  <= 1'b0;
      paused      <= 1'b0;
      cts_out_reg <= 1'b0;
      d1_reg      <= 1'b0;
      d2_reg      <= 1'b0;
      d3_reg      <= 1'b0;
      dtr_lvl_reg <= 1'b0;
    end
    else
    begin
      // Printer does not drive this line, so the host holds it true
      cts_out_reg <= 1'b1;
      d1_reg      <= link.dtr;
      d2_reg      <= d1_reg;
      d3_reg      <= d2_reg;
      if (d2_reg == d3_reg)
        dtr_lvl_reg <= d3_reg;
      start_reg   <= accept;
      send_ready  <= can_snd;
      if (accept)
        data_reg <= send_data;
      if (!xonoff_en)
        paused <= 1'b0;
      else if (recv_valid && !recv_perr && !recv_ferr)
      begin
        if (recv_data == CH_XOFF)
          paused <= 1'b1;
        else if (recv_data == CH_XON)
          paused <= 1'b0;
      end
    end
  end
endmodule : psr_host_end
`default_nettype wire

/* File: tb/psr_link_monitor.sv */
`default_nettype none
module psr_link_monitor
  import psr_pkg::*;
#(
  parameter logic [15:0] BIT_DIV_9600 = DIV_9600
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rd,
  input wire logic td,
  input wire logic cts,
  input wire logic dtr,
  input wire logic rts
);
  timeunit 1ns;
  timeprecision 1ps;
  // Longest legal low run: start bit, eight zero data bits, zero parity
  localparam int MAX_LOW = 10 * int'(BIT_DIV_9600);
  logic [15:0] td_low_reg;
  logic [15:0] rd_low_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      td_low_reg <= 16'h0000;
      rd_low_reg <= 16'h0000;
    end
    else
    begin
      td_low_reg <= td ? 16'h0000 : td_low_reg + 16'h0001;
      rd_low_reg <= rd ? 16'h0000 : rd_low_reg + 16'h0001;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IDLE_AFTER_RESET: assert property (!$past(presetn) |-> td && rd && !dtr)
    else $error("lines not idle after reset");
  AST_CTS_HELD: assert property ($past(presetn) && $past(presetn, 2) |-> cts)
    else $error("clear-to-send not held high");
  // Four cycles is the shortest bit at the fastest rate with this divider
  AST_TD_BIT_LOW: assert property ($fell(td) |-> !td [*4])
    else $error("printer low bit too short");
  AST_TD_BIT_HIGH: assert property ($rose(td) |-> td [*4])
    else $error("printer high bit too short");
  AST_RD_BIT_LOW: assert property ($fell(rd) |-> !rd [*4])
    else $error("host low bit too short");
  AST_TD_STOP_BIT: assert property (td_low_reg <= MAX_LOW)
    else $error("printer frame without stop bit");
  AST_RD_STOP_BIT: assert property (rd_low_reg <= MAX_LOW)
    else $error("host frame without stop bit");
  AST_HALF_DUPLEX: assert property ($fell(td) |-> rd && $past(rd))
    else $error("printer sends while host sends");
  AST_FAULT_BUSY: assert property (!rts && !$past(rts) |-> !dtr)
    else $error("ready while in fault");

  cover property ($fell(td));
  cover property ($fell(rd));
  cover property ($fell(dtr));
  cover property (!rts);
endmodule : psr_link_monitor
`default_nettype wire

/* File: tb/printer_host_serial_receiver_tb_top.sv */
`default_nettype none
module printer_host_serial_receiver_tb_top
  import psr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short bit time keeps the run small; 57600 still gets four cycles a bit
  localparam logic [15:0] DIV = 16'h0018;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  rate_sel, parity_sel;
  logic        xonoff_en, send_valid, send_ready, recv_valid, recv_perr, recv_ferr, paused;
  logic [7:0]  send_data, recv_data;
  logic [7:0]  ctl [5] = '{CH_STX, CH_ETX, CH_ACK, CH_NAK, 8'h8A};
  int          num_errors, compares;

  psr_link_if link_if ();
  psr_printer_end #(.BIT_DIV_9600(DIV)) psr_printer_end_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if.printer));
  psr_host_end #(.BIT_DIV_9600(DIV)) psr_host_end_inst (.pclk(pclk), .presetn(presetn),
    .rate_sel(rate_sel), .parity_sel(parity_sel), .xonoff_en(xonoff_en),
    .send_valid(send_valid), .send_data(send_data), .send_ready(send_ready),
    .recv_valid(recv_valid), .recv_data(recv_data), .recv_perr(recv_perr),
    .recv_ferr(recv_ferr), .paused(paused), .link(link_if.host));
  psr_link_monitor #(.BIT_DIV_9600(DIV)) psr_link_monitor_inst (.pclk(pclk),
    .presetn(presetn), .rd(link_if.rd), .td(link_if.td), .cts(link_if.cts),
    .dtr(link_if.dtr), .rts(link_if.rts));

  always #12.5 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rdat, exp);
  endtask : rchk

  task automatic wait_stat(input int b, input logic v);
    do
      apb(1'b0, REG_STAT, 32'h0000_0000);
    while (rdat[b] !== v);
  endtask : wait_stat

  task automatic rx_pop(input logic [7:0] exp);
    wait_stat(STAT_EMPTY, 1'b0);
    rchk("printer byte", REG_RXDATA, {24'h00_0000, exp});
  endtask : rx_pop

  task automatic cfg(input logic [6:0] c);
    apb(1'b1, REG_CTRL, {25'h000_0000, c});
    {xonoff_en, parity_sel, rate_sel} <= {c[5], c[3:0]};
  endtask : cfg

  task automatic hsend(input logic [7:0] b);
    @(posedge pclk);
    {send_valid, send_data} <= {1'b1, b};
    do
      @(posedge pclk);
    while (send_ready !== 1'b1);
    send_valid <= 1'b0;
  endtask : hsend

  task automatic hrecv(input logic [7:0] exp);
    do
      @(posedge pclk);
    while (recv_valid !== 1'b1);
    chk("host byte", {24'h00_0000, recv_data}, {24'h00_0000, exp});
    chk("host errors", {30'h0000_0000, recv_perr, recv_ferr}, 32'h0000_0000);
  endtask : hrecv

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rate_sel, parity_sel, xonoff_en, send_valid, send_data} = '0;
    num_errors = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl reset", REG_CTRL, 32'h0000_0000);
    rchk("stat reset", REG_STAT, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_00FF);
    chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
    rchk("ctrl untouched", REG_CTRL, 32'h0000_0000);
    chk("dtr off-line", {31'h0000_0000, link_if.dtr}, 32'h0000_0000);
    chk("td idle", {31'h0000_0000, link_if.td}, 32'h0000_0001);
    $display("test reset done");
    for (int r = 0; r < 4; r++)
      for (int p = 0; p < 3; p++)
      begin
        cfg(7'(16 + p * 4 + r));
        apb(1'b1, REG_TXDATA, {24'h00_0000, 8'h5A ^ 8'(r * 3 + p)});
        hrecv(8'h5A ^ 8'(r * 3 + p));
        // Printer ignores frames that start while it still sends
        wait_stat(STAT_TXBUSY, 1'b0);
        hsend(8'hC3 ^ 8'(r * 5 + p));
        rx_pop(8'hC3 ^ 8'(r * 5 + p));
      end
    $display("test rates and parities done");
    cfg(7'h10);
    apb(1'b1, REG_STAT, 32'h0000_0FE0);
    foreach (ctl[i])
    begin
      hsend(ctl[i]);
      rx_pop(ctl[i]);
    end
    rchk("sticky flags", REG_STAT, 32'h0000_03E1);
    apb(1'b1, REG_STAT, 32'h0000_03E0);
    rchk("sticky cleared", REG_STAT, 32'h0000_0001);
    $display("test control characters done");
    cfg(7'h30);
    for (int i = 0; i < 12; i++)
      hsend(8'(i));
    do
      apb(1'b0, REG_STAT, 32'h0000_0000);
    while (rdat[20:16] !== 5'h0C);
    do
      @(posedge pclk);
    while (paused !== 1'b1);
    chk("dtr near full", {31'h0000_0000, link_if.dtr}, 32'h0000_0000);
    chk("xoff byte", {24'h00_0000, recv_data}, {24'h00_0000, CH_XOFF});
    for (int i = 0; i < 12; i++)
      rx_pop(8'(i));
    do
      @(posedge pclk);
    while (paused !== 1'b0);
    chk("host resumed", {31'h0000_0000, paused}, 32'h0000_0000);
    chk("xon byte", {24'h00_0000, recv_data}, {24'h00_0000, CH_XON});
    chk("dtr drained", {31'h0000_0000, link_if.dtr}, 32'h0000_0001);
    $display("test flow control done");
    cfg(7'h50);
    repeat (3) @(posedge pclk);
    chk("rts on fault", {31'h0000_0000, link_if.rts}, 32'h0000_0000);
    chk("dtr on fault", {31'h0000_0000, link_if.dtr}, 32'h0000_0000);
    cfg(7'h00);
    repeat (3) @(posedge pclk);
    chk("rts cleared", {31'h0000_0000, link_if.rts}, 32'h0000_0001);
    chk("dtr off-line", {31'h0000_0000, link_if.dtr}, 32'h0000_0000);
    $display("test fault done");
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    $display("unexpected run length: expected end seen hang");
    end_of_test();
  end
endmodule : printer_host_serial_receiver_tb_top
`default_nettype wire
